//--- pkg/wdg_pkg.sv
// wdg_pkg: constants and types for the 24-bit watchdog block
// assumes an APB slave with 32-bit data and a 25 MHz pclk
package wdg_pkg;

  // bus geometry
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int IDX_W = 12;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] CTL_IDX = 12'hFF0;
  localparam logic [IDX_W-1:0] UPPER_IDX = 12'hFF1;
  localparam logic [IDX_W-1:0] HIGH_IDX = 12'hFF2;
  localparam logic [IDX_W-1:0] LOW_IDX = 12'hFF3;
  localparam logic [IDX_W-1:0] OPT_IDX = 12'hFF4;

  // control register status bit positions
  localparam int POR_BIT = 7;
  localparam int STOP_BIT = 6;
  localparam int TMO_BIT = 5;
  localparam int EXT_BIT = 4;

  // option register bit positions
  localparam int AO_BIT = 0;
  localparam int RES_BIT = 1;
  localparam logic [1:0] OPT_RESET = 2'h0;

  // key values written to the control address
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] STOP_OFF_CODE = 8'h81;
  localparam logic [7:0] STOP_ON_CODE = 8'h00;

  // counter values
  localparam logic [23:0] RELOAD_RESET = 24'hFFFFFF;
  localparam logic [23:0] REFRESH_LIMIT = 24'h000002;
  localparam logic [23:0] COUNT_LAST = 24'h000001;
  localparam logic [23:0] COUNT_ONE = 24'h000001;
  localparam logic [23:0] COUNT_RESET = 24'h000000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // timing: oscillator against bus clock
  localparam int OSC_FREQ_KHZ = 10;
  localparam int PCLK_FREQ_KHZ = 25000;
  localparam int OSC_PERIOD_CYCLES = PCLK_FREQ_KHZ / OSC_FREQ_KHZ;

  // reload unlock sequencer states
  typedef enum logic [4:0] {
    UNL_IDLE = 5'h01,
    UNL_KEY1 = 5'h02,
    UNL_KEY2 = 5'h04,
    UNL_UPPER = 5'h08,
    UNL_HIGH = 5'h10
  } wdg_unlock_t;

endpackage

//--- rtl/wdg_osc_tick.sv
// wdg_osc_tick: turns the free watchdog oscillator pin into a pclk enable
// assumes pclk runs far faster than the oscillator
`timescale 1ns/100ps
`default_nettype none
module wdg_osc_tick (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // oscillator pin
  input wire logic osc_pin,
  // one-cycle enable per oscillator rising edge
  output logic osc_tick
);

  logic sync1;
  logic sync2;
  logic sync2_prev;

  // two-stage synchroniser, then edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync2_prev <= 1'b0;
    end else begin
      sync1 <= osc_pin;
      sync2 <= sync1;
      sync2_prev <= sync2;
    end
  end

  // rising edge pulse, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= sync2 & ~sync2_prev;
    end
  end

endmodule // wdg_osc_tick
`default_nettype wire

//--- rtl/wdg_watchdog.sv
// wdg_watchdog: 24-bit reloadable down-counting watchdog with APB registers
// assumes core strobes on pclk, oscillator pin asynchronous to pclk
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module wdg_watchdog (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdg_pkg::ADDR_W-1:0] paddr,
  input wire logic [wdg_pkg::DATA_W-1:0] pwdata,
  output logic [wdg_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // watchdog oscillator pin
  input wire logic osc_pin,
  // core status and strobes
  input wire logic refresh_insn,
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire logic ext_reset_seen,
  // responses
  output logic timeout_irq,
  output logic chip_reset_req,
  output logic stop_recovery_req,
  output logic osc_run
);

  // index to byte address
  function automatic logic [wdg_pkg::ADDR_W-1:0] idx_addr(input logic [wdg_pkg::IDX_W-1:0] idx);
    idx_addr = {idx, 2'b00};
  endfunction

  // byte lane of the count selected by a reload register index
  function automatic logic [7:0] count_byte(input logic [23:0] cnt, input logic [wdg_pkg::IDX_W-1:0] idx);
    unique case (idx)
      wdg_pkg::UPPER_IDX: count_byte = cnt[23:16];
      wdg_pkg::HIGH_IDX: count_byte = cnt[15:8];
      default: count_byte = cnt[7:0];
    endcase
  endfunction

  logic osc_tick;
  logic [23:0] count;
  logic [23:0] reload;
  logic enabled;
  logic stop_disable;
  logic always_on_option;
  logic timeout_response_option;
  logic [3:0] status;
  wdg_pkg::wdg_unlock_t unlock_state;
  wdg_pkg::wdg_unlock_t next_unlock_state;

  logic access;
  logic wr_en;
  logic rd_en;
  logic hit_ctl;
  logic hit_upper;
  logic hit_high;
  logic hit_low;
  logic hit_opt;
  logic hit_any;
  logic [7:0] wbyte;
  logic enable_req;
  logic counting;
  logic refresh_load;
  logic timeout;
  logic stop_seq_write;

  // oscillator edge to pclk enable
  wdg_osc_tick u_osc_tick (
    .pclk(pclk),
    .presetn(presetn),
    .osc_pin(osc_pin),
    .osc_tick(osc_tick)
  );

  // apb decode
  assign access = psel & penable;
  assign wr_en = access & pwrite;
  assign rd_en = access & ~pwrite;
  assign hit_ctl = (paddr == idx_addr(wdg_pkg::CTL_IDX));
  assign hit_upper = (paddr == idx_addr(wdg_pkg::UPPER_IDX));
  assign hit_high = (paddr == idx_addr(wdg_pkg::HIGH_IDX));
  assign hit_low = (paddr == idx_addr(wdg_pkg::LOW_IDX));
  assign hit_opt = (paddr == idx_addr(wdg_pkg::OPT_IDX));
  assign hit_any = hit_ctl | hit_upper | hit_high | hit_low | hit_opt;
  assign wbyte = pwdata[7:0];

  // zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = access & ~hit_any;

  // read data captured in the setup cycle, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel & ~penable & ~pwrite) begin
      if (hit_ctl) begin
        prdata <= {24'h000000, status, 4'h0};
      end else if (hit_upper | hit_high | hit_low) begin
        prdata <= {24'h000000, count_byte(count, paddr[wdg_pkg::ADDR_W-1:2])};
      end else if (hit_opt) begin
        prdata <= {30'h00000000, timeout_response_option, always_on_option};
      end else begin
        prdata <= '0;
      end
    end
  end

  // unlock sequencer: keys then stop code, or keys then ordered reload bytes
  always_comb begin
    next_unlock_state = unlock_state;
    stop_seq_write = 1'b0;
    if (wr_en) begin
      next_unlock_state = wdg_pkg::UNL_IDLE; // any out-of-order write aborts
      unique case (unlock_state)
        wdg_pkg::UNL_IDLE: begin
          if (hit_ctl && wbyte == wdg_pkg::KEY_FIRST) begin
            next_unlock_state = wdg_pkg::UNL_KEY1;
          end
        end
        wdg_pkg::UNL_KEY1: begin
          if (hit_ctl && wbyte == wdg_pkg::KEY_SECOND) begin
            next_unlock_state = wdg_pkg::UNL_KEY2;
          end else if (hit_ctl && wbyte == wdg_pkg::KEY_FIRST) begin
            next_unlock_state = wdg_pkg::UNL_KEY1;
          end
        end
        wdg_pkg::UNL_KEY2: begin
          if (hit_upper) begin
            next_unlock_state = wdg_pkg::UNL_UPPER;
          end else if (hit_ctl && (wbyte == wdg_pkg::STOP_OFF_CODE || wbyte == wdg_pkg::STOP_ON_CODE)) begin
            stop_seq_write = 1'b1;
          end else if (hit_ctl && wbyte == wdg_pkg::KEY_FIRST) begin
            next_unlock_state = wdg_pkg::UNL_KEY1;
          end
        end
        wdg_pkg::UNL_UPPER: begin
          if (hit_high) begin
            next_unlock_state = wdg_pkg::UNL_HIGH;
          end
        end
        wdg_pkg::UNL_HIGH: begin
          next_unlock_state = wdg_pkg::UNL_IDLE;
        end
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_state <= wdg_pkg::UNL_IDLE;
    end else begin
      unlock_state <= next_unlock_state;
    end
  end

  // reload bytes, writable only at their turn in the unlock sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload <= wdg_pkg::RELOAD_RESET;
    end else if (wr_en) begin
      if (unlock_state == wdg_pkg::UNL_KEY2 && hit_upper) begin
        reload[23:16] <= wbyte;
      end
      if (unlock_state == wdg_pkg::UNL_UPPER && hit_high) begin
        reload[15:8] <= wbyte;
      end
      if (unlock_state == wdg_pkg::UNL_HIGH && hit_low) begin
        reload[7:0] <= wbyte;
      end
    end
  end

  // stop-mode disable flag, default running in stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_disable <= 1'b0;
    end else if (stop_seq_write) begin
      stop_disable <= (wbyte == wdg_pkg::STOP_OFF_CODE);
    end
  end

  // option bits held in a software register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      always_on_option <= wdg_pkg::OPT_RESET[wdg_pkg::AO_BIT];
      timeout_response_option <= wdg_pkg::OPT_RESET[wdg_pkg::RES_BIT];
    end else if (wr_en && hit_opt) begin
      always_on_option <= pwdata[wdg_pkg::AO_BIT];
      timeout_response_option <= pwdata[wdg_pkg::RES_BIT];
    end
  end

  // enable, reload and count conditions
  assign enable_req = refresh_insn | always_on_option;
  assign counting = enabled & ~(stop_mode & stop_disable);
  assign refresh_load = debug_mode | (refresh_insn & (count > wdg_pkg::REFRESH_LIMIT));
  assign timeout = counting & ~refresh_load & osc_tick & (count == wdg_pkg::COUNT_LAST);

  // on latch: once on, stays on until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enabled <= 1'b0;
    end else if (enable_req) begin
      enabled <= 1'b1;
    end
  end

  // the down-counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= wdg_pkg::COUNT_RESET;
    end else if (!enabled) begin
      if (enable_req) begin
        count <= reload;
      end
    end else if (refresh_load) begin
      count <= reload;
    end else if (counting && osc_tick) begin
      count <= count - wdg_pkg::COUNT_ONE;
    end
  end

  // oscillator run request follows the stop disable setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run <= 1'b1;
    end else begin
      osc_run <= ~(stop_mode & stop_disable);
    end
  end

  // timeout responses as one-cycle pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_irq <= 1'b0;
      chip_reset_req <= 1'b0;
      stop_recovery_req <= 1'b0;
    end else begin
      timeout_irq <= timeout & ~timeout_response_option;
      chip_reset_req <= timeout & timeout_response_option & ~stop_mode;
      stop_recovery_req <= timeout & timeout_response_option & stop_mode;
    end
  end

  // status bits: events set, control read clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 4'h8; // power-on marker set at reset
    end else begin
      if (rd_en && hit_ctl) begin
        status <= 4'h0;
      end
      if (ext_reset_seen) begin
        status[wdg_pkg::EXT_BIT-4] <= 1'b1;
      end
      if (timeout) begin
        status[wdg_pkg::POR_BIT-4] <= 1'b0;
        status[wdg_pkg::TMO_BIT-4] <= 1'b1;
        status[wdg_pkg::STOP_BIT-4] <= stop_mode & timeout_response_option;
      end
    end
  end

endmodule // wdg_watchdog
`default_nettype wire

//--- verif/wdg_osc_model.sv
// wdg_osc_model: stand-in for the watchdog's own rc oscillator
// assumes the bench gates it and the device reports osc_run
`timescale 1ns/100ps
`default_nettype none
module wdg_osc_model (
  // gating
  input wire logic osc_en,
  input wire logic osc_run,
  // oscillator pin
  output logic osc_pin
);
  // own timebase, unrelated to pclk; parked low while stopped
  initial begin
    osc_pin = 1'b0;
    forever begin
      #370;
      osc_pin = (osc_en && osc_run) ? ~osc_pin : 1'b0;
    end
  end
endmodule // wdg_osc_model
`default_nettype wire

//--- verif/wdg_watchdog_assertions.sv
// wdg_watchdog_chk: port-level checks of the watchdog block
// assumes it is bound to wdg_watchdog and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module wdg_watchdog_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdg_pkg::ADDR_W-1:0] paddr,
  input wire logic [wdg_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire logic timeout_irq,
  input wire logic chip_reset_req,
  input wire logic stop_recovery_req,
  input wire logic osc_run
);
  logic mapped;
  logic rd;
  // decode of the five register words
  assign mapped = paddr[13:2] >= 12'hFF0 && paddr[13:2] <= 12'hFF4;
  assign rd = psel && penable && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr) else $error("no slave error");
  a_err_mapped: assert property (psel && penable && mapped |-> !pslverr) else $error("bad slave error");
  a_unmap_zero: assert property (rd && !mapped |-> prdata == 32'h0) else $error("unmapped data");
  a_ctl_rsvd: assert property (rd && paddr == 14'h3FC0 |-> prdata[3:0] == 4'h0) else $error("ctl low bits");
  a_irq_pulse: assert property (timeout_irq |=> !timeout_irq) else $error("irq not a pulse");
  a_one_resp: assert property ($onehot0({timeout_irq, chip_reset_req, stop_recovery_req})) else $error("two responses");
  a_reset_run: assert property (chip_reset_req |-> !stop_mode) else $error("reset in stop");
  a_recov_stop: assert property (stop_recovery_req |-> stop_mode) else $error("recovery outside stop");
  a_debug_quiet: assert property (debug_mode [*3] |-> !timeout_irq && !chip_reset_req) else $error("debug timeout");
  a_osc_awake: assert property (!stop_mode |=> osc_run) else $error("osc stopped");
endmodule // wdg_watchdog_chk
bind wdg_watchdog wdg_watchdog_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .debug_mode, .stop_mode, .timeout_irq, .chip_reset_req, .stop_recovery_req, .osc_run);
`default_nettype wire

//--- verif/wdg_watchdog_bench.sv
// wdg_watchdog_bench: self-checking bench for the watchdog block
// assumes wdg_pkg, the oscillator model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module wdg_watchdog_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_pin, osc_en, osc_run;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata;
  logic refresh_insn, debug_mode, stop_mode, ext_reset_seen, timeout_irq, chip_reset_req, stop_recovery_req;
  logic [7:0] rdq[$];
  logic [2:0] evq[$];
  logic [7:0] lo;
  logic [31:0] exp_rd;
  logic [2:0] exp_ev;
  int err_count = 0;
  int tests_run = 0;
  int seed;
  wdg_watchdog dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_pin(osc_pin),
    .refresh_insn(refresh_insn), .debug_mode(debug_mode), .stop_mode(stop_mode), .ext_reset_seen(ext_reset_seen),
    .timeout_irq(timeout_irq), .chip_reset_req(chip_reset_req), .stop_recovery_req(stop_recovery_req),
    .osc_run(osc_run));
  wdg_osc_model osc_u (.osc_en(osc_en), .osc_run(osc_run), .osc_pin(osc_pin));
  // clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // one apb transfer; a read notes its expected byte first
  task automatic apb(input logic w, input logic [11:0] ix, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the run watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] ix, input logic [7:0] e);
    rdq.push_back(e);
    apb(1'b0, ix, 8'h00);
  endtask
  task automatic key(input logic [7:0] third, input logic [11:0] ix);
    apb(1'b1, wdg_pkg::CTL_IDX, wdg_pkg::KEY_FIRST);
    apb(1'b1, wdg_pkg::CTL_IDX, wdg_pkg::KEY_SECOND);
    apb(1'b1, ix, third);
  endtask
  task automatic pulse_refresh();
    @(posedge pclk);
    refresh_insn <= 1'b1;
    @(posedge pclk);
    refresh_insn <= 1'b0;
  endtask
  // note an expected response pulse and wait for it
  task automatic wait_ev(input logic [2:0] e);
    int n;
    evq.push_back(e);
    n = 0;
    while (evq.size() != 0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (evq.size() != 0) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // monitor: read data and response pulses against the oldest notes
  always @(posedge pclk) begin
    // pop once into a local so the mismatch print does not pop again
    if (psel && penable && !pwrite && pready === 1'b1) begin
      exp_rd = {24'h0, rdq.pop_front()};
      `CHK(prdata, exp_rd)
    end
    if (timeout_irq || chip_reset_req || stop_recovery_req) begin
      exp_ev = evq.size() ? evq.pop_front() : 3'h0;
      `CHK({timeout_irq, chip_reset_req, stop_recovery_req}, exp_ev)
    end
  end
  // watchdog on the run itself
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, refresh_insn, debug_mode, stop_mode, ext_reset_seen, osc_en} = '0;
    paddr = '0;
    pwdata = '0;
    seed = $urandom(32'h14E2);
    lo = 8'h04 + 8'($urandom % 8);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(wdg_pkg::CTL_IDX, 8'h80);
    rd(wdg_pkg::CTL_IDX, 8'h00);
    rd(12'hFF8, 8'h00);
    @(posedge pclk);
    ext_reset_seen <= 1'b1;
    @(posedge pclk);
    ext_reset_seen <= 1'b0;
    rd(wdg_pkg::CTL_IDX, 8'h10);
    key(8'h00, wdg_pkg::UPPER_IDX);
    apb(1'b1, wdg_pkg::HIGH_IDX, 8'h00);
    apb(1'b1, wdg_pkg::LOW_IDX, lo);
    apb(1'b1, wdg_pkg::OPT_IDX, 8'h00);
    pulse_refresh();
    rd(wdg_pkg::LOW_IDX, lo);
    osc_en <= 1'b1;
    wait_ev(3'b100);
    rd(wdg_pkg::CTL_IDX, 8'h20);
    // let the next oscillator tick wrap the count below zero
    repeat (40) @(posedge pclk);
    rd(wdg_pkg::UPPER_IDX, 8'hFF);
    debug_mode <= 1'b1;
    repeat (600) @(posedge pclk);
    debug_mode <= 1'b0;
    apb(1'b1, wdg_pkg::OPT_IDX, 8'h02);
    rd(wdg_pkg::OPT_IDX, 8'h02);
    wait_ev(3'b010);
    rd(wdg_pkg::CTL_IDX, 8'h20);
    // count sits at zero until the next tick: refresh must not reload
    pulse_refresh();
    rd(wdg_pkg::LOW_IDX, 8'h00);
    repeat (40) @(posedge pclk);
    stop_mode <= 1'b1;
    pulse_refresh();
    wait_ev(3'b001);
    stop_mode <= 1'b0;
    rd(wdg_pkg::CTL_IDX, 8'h60);
    // wrap past zero so the refresh in stop is above the limit
    repeat (40) @(posedge pclk);
    key(wdg_pkg::STOP_OFF_CODE, wdg_pkg::CTL_IDX);
    stop_mode <= 1'b1;
    repeat (5) @(posedge pclk);
    pulse_refresh();
    rd(wdg_pkg::LOW_IDX, lo);
    repeat (300) @(posedge pclk);
    rd(wdg_pkg::LOW_IDX, lo);
    key(wdg_pkg::STOP_ON_CODE, wdg_pkg::CTL_IDX);
    wait_ev(3'b001);
    stop_mode <= 1'b0;
    repeat (5) @(posedge pclk);
    end_of_test();
  end
endmodule // wdg_watchdog_bench
`default_nettype wire
